// *** common/dscr_pkg.sv ***
`default_nettype none
package dscr_pkg;
    localparam logic [7:0] OFF_OSC_PWIRE = 8'h0a;
    localparam logic [7:0] OFF_MEM_CAP = 8'h0c;
    localparam logic [7:0] OFF_STAT = 8'h10;
    localparam logic [7:0] OFF_PC = 8'h11;
    localparam logic [7:0] OFF_SP = 8'h12;
    localparam logic [7:0] OFF_T_SEL = 8'h13;
    localparam logic [7:0] OFF_R_SEL = 8'h14;
    localparam logic [7:0] OFF_CAUSE = 8'h15;
    localparam logic [7:0] OFF_PAYLOAD = 8'h16;
    localparam logic [7:0] OFF_HOLD = 8'h18;
    localparam logic [4:0] OFF_MBOX_BASE = 5'h04;
    localparam int OSC_W = 16;
    localparam int STAT_W = 11;
    localparam logic [10:0] STAT_CAP_MASK = 11'h7df;
    localparam logic [10:0] STAT_WR_MASK = 11'h6df;
    localparam int STAT_ISSUE_BIT = 8;
    localparam int CAUSE_LSB = 0;
    localparam int THREAD_LSB = 8;
    localparam int INDEX_LSB = 16;
    localparam logic [2:0] CAUSE_NONE = 3'h0;
    localparam logic [2:0] CAUSE_HOST = 3'h1;
    localparam logic [2:0] CAUSE_DBG_CALL = 3'h2;
    localparam logic [2:0] CAUSE_IBRK = 3'h3;
    localparam logic [2:0] CAUSE_DWATCH = 3'h4;
    localparam logic [2:0] CAUSE_RWATCH = 3'h5;
    localparam logic [31:0] RST_WORD = 32'h0000_0000;
    localparam logic [31:0] RAM_BYTES_DEF = 32'h0004_0000;
endpackage
`default_nettype wire

// *** design/dscr_regs.sv ***
`default_nettype none
// Function
// - Low 16 bits return oscillator count
// - Oscillator count survives system reset
// - Read-only RAM size word at 0x0c
// - Debug entry copies saved status word
// - Status bits 0-4 flags, bit 5 reserved
// - Bit 7 fast mode, bit 6 paused
// - Bit 8 read-only issue mode, 9-10 writable
// - Debug entry captures saved program counter
// - Debug entry captures saved stack pointer
// - Eight-bit thread select operand at 0x13
// - Five-bit register select operand at 0x14
// - Cause code encoding, resets to zero
// - Lowest firing watchpoint index, zero otherwise
// - Thread number, forced zero for host
// - Data watchpoint loads effective address
// - Resource watchpoint loads resource identifier
// - Hold mask stops cores after return
// - Eight mailbox words shared with config space
module dscr_regs
    import dscr_pkg::*;
#(
    parameter logic [31:0] RAM_BYTES = RAM_BYTES_DEF,
    parameter int NUM_WP = 4,
    parameter int MBOX_WORDS = 8
) (
    input wire logic mclk,
    input wire logic sys_rst,
    input wire logic osc_rst,
    input wire logic osc_enable,
    input wire logic osc_tick,
    input wire logic dbg_mode,
    input wire logic [7:0] ps_addr,
    input wire logic ps_wr,
    input wire logic ps_rd,
    input wire logic [31:0] ps_wdata,
    output logic [31:0] ps_rdata,
    output logic ps_rvalid,
    input wire logic [2:0] cfg_addr,
    input wire logic cfg_wr,
    input wire logic cfg_rd,
    input wire logic [31:0] cfg_wdata,
    output logic [31:0] cfg_rdata,
    input wire logic dbg_enter,
    input wire logic [10:0] ent_status,
    input wire logic [31:0] ent_pc,
    input wire logic [31:0] ent_sp,
    input wire logic [2:0] ent_cause,
    input wire logic [7:0] ent_thread,
    input wire logic [NUM_WP-1:0] ent_hits,
    input wire logic [31:0] ent_addr,
    input wire logic [31:0] ent_res_id,
    output logic [7:0] core_stop
);
    logic [OSC_W-1:0] osc_cnt_reg;
    logic [STAT_W-1:0] stat_reg;
    logic [31:0] pc_reg;
    logic [31:0] sp_reg;
    logic [7:0] tsel_reg;
    logic [4:0] rsel_reg;
    logic [2:0] cause_reg;
    logic [7:0] cthread_reg;
    logic [1:0] cindex_reg;
    logic [31:0] payload_reg;
    logic [7:0] hold_reg;
    logic [31:0] mbox_mem [MBOX_WORDS];
    logic [31:0] ps_rdata_reg;
    logic ps_rvalid_reg;
    logic [31:0] cfg_rdata_reg;
    logic [7:0] core_stop_reg;
    logic dwr;
    logic [1:0] hit_index;

    function automatic logic [1:0] lowest_hit(input logic [NUM_WP-1:0] hits);
        logic [1:0] idx;
        idx = 2'h0;
        for (int i = NUM_WP - 1; i >= 0; i--) begin
            if (hits[i]) begin
                idx = 2'(i);
            end
        end
        return idx;
    endfunction

    function automatic logic is_mbox(input logic [7:0] a);
        return a[7:3] == OFF_MBOX_BASE;
    endfunction

    // Register writes only count while the tile is in debug mode
    assign dwr = ps_wr && dbg_mode;
    assign hit_index = lowest_hit(ent_hits);

    // Cleared only by its own reset; sys_rst deliberately absent
    always_ff @(posedge mclk) begin
        if (osc_rst) begin
            osc_cnt_reg <= '0;
        end else if (osc_enable && osc_tick) begin
            osc_cnt_reg <= osc_cnt_reg + 16'h0001;
        end
    end

    // Capture wins over a software write in the same cycle
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            stat_reg <= '0;
            pc_reg <= RST_WORD;
            sp_reg <= RST_WORD;
        end else if (dbg_enter) begin
            stat_reg <= ent_status & STAT_CAP_MASK;
            pc_reg <= ent_pc;
            sp_reg <= ent_sp;
        end else if (dwr) begin
            if (ps_addr == OFF_STAT) begin
                stat_reg <= (ps_wdata[STAT_W-1:0] & STAT_WR_MASK)
                    | (stat_reg & ~STAT_WR_MASK);
            end
            if (ps_addr == OFF_PC) begin
                pc_reg <= ps_wdata;
            end
            if (ps_addr == OFF_SP) begin
                sp_reg <= ps_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            cause_reg <= CAUSE_NONE;
            cthread_reg <= '0;
            cindex_reg <= '0;
            payload_reg <= RST_WORD;
        end else if (dbg_enter) begin
            cause_reg <= ent_cause;
            cthread_reg <= (ent_cause == CAUSE_HOST) ? 8'h00 : ent_thread;
            cindex_reg <= (ent_cause == CAUSE_HOST || ent_cause == CAUSE_DBG_CALL)
                ? 2'h0 : hit_index;
            if (ent_cause == CAUSE_DWATCH) begin
                payload_reg <= ent_addr;
            end else if (ent_cause == CAUSE_RWATCH) begin
                payload_reg <= ent_res_id;
            end
        end else if (dwr) begin
            if (ps_addr == OFF_CAUSE) begin
                cause_reg <= ps_wdata[CAUSE_LSB +: 3];
                cthread_reg <= ps_wdata[THREAD_LSB +: 8];
                cindex_reg <= ps_wdata[INDEX_LSB +: 2];
            end
            if (ps_addr == OFF_PAYLOAD) begin
                payload_reg <= ps_wdata;
            end
        end
    end

    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            tsel_reg <= '0;
            rsel_reg <= '0;
            hold_reg <= '0;
        end else if (dwr) begin
            if (ps_addr == OFF_T_SEL) begin
                tsel_reg <= ps_wdata[7:0];
            end
            if (ps_addr == OFF_R_SEL) begin
                rsel_reg <= ps_wdata[4:0];
            end
            if (ps_addr == OFF_HOLD) begin
                hold_reg <= ps_wdata[7:0];
            end
        end
    end

    // Mask only bites once debug mode is left
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            core_stop_reg <= '0;
        end else begin
            core_stop_reg <= dbg_mode ? 8'h00 : hold_reg;
        end
    end

    // One array for both ports; the processor side wins a collision
    always_ff @(posedge mclk) begin
        if (dwr && is_mbox(ps_addr)) begin
            mbox_mem[ps_addr[2:0]] <= ps_wdata;
        end
        if (cfg_wr && !(dwr && is_mbox(ps_addr) && ps_addr[2:0] == cfg_addr)) begin
            mbox_mem[cfg_addr] <= cfg_wdata;
        end
    end

    // Reads return the value from before a same-cycle write
    always_ff @(posedge mclk) begin
        if (sys_rst) begin
            ps_rdata_reg <= RST_WORD;
            ps_rvalid_reg <= 1'b0;
            cfg_rdata_reg <= RST_WORD;
        end else begin
            ps_rvalid_reg <= ps_rd;
            if (cfg_rd) begin
                cfg_rdata_reg <= mbox_mem[cfg_addr];
            end
            if (ps_rd) begin
                if (is_mbox(ps_addr)) begin
                    ps_rdata_reg <= mbox_mem[ps_addr[2:0]];
                end else begin
                    unique case (ps_addr)
                        OFF_OSC_PWIRE: ps_rdata_reg <= {16'h0000, osc_cnt_reg};
                        OFF_MEM_CAP: ps_rdata_reg <= {RAM_BYTES[31:2], 2'b00};
                        OFF_STAT: ps_rdata_reg <= {21'h000000, stat_reg};
                        OFF_PC: ps_rdata_reg <= pc_reg;
                        OFF_SP: ps_rdata_reg <= sp_reg;
                        OFF_T_SEL: ps_rdata_reg <= {24'h000000, tsel_reg};
                        OFF_R_SEL: ps_rdata_reg <= {27'h0000000, rsel_reg};
                        OFF_CAUSE: ps_rdata_reg <= {14'h0000, cindex_reg, cthread_reg,
                            5'h00, cause_reg};
                        OFF_PAYLOAD: ps_rdata_reg <= payload_reg;
                        OFF_HOLD: ps_rdata_reg <= {24'h000000, hold_reg};
                        default: ps_rdata_reg <= RST_WORD;
                    endcase
                end
            end
        end
    end

    assign ps_rdata = ps_rdata_reg;
    assign ps_rvalid = ps_rvalid_reg;
    assign cfg_rdata = cfg_rdata_reg;
    assign core_stop = core_stop_reg;

    osc_count_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (osc_enable && osc_tick && !osc_rst) |=> osc_cnt_reg == $past(osc_cnt_reg) + 16'h0001)
        else $error("oscillator count did not advance");
    osc_keep_a: assert property (@(posedge mclk)
        (sys_rst && !osc_rst && !osc_tick) |=> $stable(osc_cnt_reg))
        else $error("oscillator count disturbed by system reset");
    ram_read_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ps_rd && ps_addr == OFF_MEM_CAP) |=> ps_rvalid && ps_rdata == {RAM_BYTES[31:2], 2'b00})
        else $error("RAM size read wrong");
    stat_cap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dbg_enter |=> stat_reg == ($past(ent_status) & STAT_CAP_MASK) && !stat_reg[5])
        else $error("status snapshot not captured");
    stat_ro_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!dbg_enter && dwr && ps_addr == OFF_STAT)
        |=> stat_reg[STAT_ISSUE_BIT] == $past(stat_reg[STAT_ISSUE_BIT]))
        else $error("issue mode bit was written");
    pc_sp_cap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dbg_enter |=> pc_reg == $past(ent_pc) && sp_reg == $past(ent_sp))
        else $error("program counter or stack pointer not captured");
    host_zero_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause == CAUSE_HOST) |=> cthread_reg == 8'h00 && cindex_reg == 2'h0
        && cause_reg == CAUSE_HOST)
        else $error("host cause left thread or index set");
    lowest_hit_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause >= CAUSE_IBRK && ent_cause <= CAUSE_RWATCH
        && ent_hits[1:0] == 2'b10) |=> cindex_reg == 2'h1)
        else $error("lowest watchpoint index not reported");
    payload_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause == CAUSE_DWATCH) |=> payload_reg == $past(ent_addr))
        else $error("watch address not loaded");
    res_payload_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause == CAUSE_RWATCH) |=> payload_reg == $past(ent_res_id))
        else $error("resource identifier not loaded");
    cause_rst_a: assert property (@(posedge mclk)
        sys_rst |=> cause_reg == CAUSE_NONE)
        else $error("cause not cleared by reset");
    wr_gate_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ps_wr && !dbg_mode) |=> $stable(hold_reg) && $stable(tsel_reg) && $stable(rsel_reg))
        else $error("write accepted outside debug mode");
    hold_out_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (!dbg_mode ##1 !dbg_mode) |=> core_stop == $past(hold_reg))
        else $error("core stop does not follow hold mask");
    mbox_share_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dwr && is_mbox(ps_addr) ##1 cfg_rd && cfg_addr == $past(ps_addr[2:0]) && !cfg_wr)
        |=> cfg_rdata == $past(ps_wdata, 2))
        else $error("mailbox word not shared");
    // Capture fields, write paths, the stop output and the oscillator read, seen one cycle after the strobe
    cause_cap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dbg_enter |=> cause_reg == $past(ent_cause))
        else $error("cause code not captured");
    thread_cap_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause != CAUSE_HOST) |=> cthread_reg == $past(ent_thread))
        else $error("causing thread not captured");
    call_index_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause == CAUSE_DBG_CALL) |=> cindex_reg == 2'h0)
        else $error("debug call left an index set");
    pay_keep_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dbg_enter && ent_cause != CAUSE_DWATCH && ent_cause != CAUSE_RWATCH)
        |=> $stable(payload_reg))
        else $error("payload changed for a non-watch cause");
    stop_dbg_a: assert property (@(posedge mclk) disable iff (sys_rst)
        dbg_mode |=> core_stop == 8'h00)
        else $error("cores held while in debug mode");
    tsel_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dwr && ps_addr == OFF_T_SEL) |=> tsel_reg == $past(ps_wdata[7:0]))
        else $error("thread select not written");
    rsel_wr_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (dwr && ps_addr == OFF_R_SEL) |=> rsel_reg == $past(ps_wdata[4:0]))
        else $error("register select not written");
    osc_upper_a: assert property (@(posedge mclk) disable iff (sys_rst)
        (ps_rd && ps_addr == OFF_OSC_PWIRE) |=> ps_rdata[31:16] == 16'h0000)
        else $error("oscillator upper bits not zero");
endmodule
`default_nettype wire

// *** sim/dscr_jtag_model.sv ***
`default_nettype none
// External debugger side of the shared mailbox words
module dscr_jtag_model
    import dscr_pkg::*;
(
    input wire logic mclk,
    output logic [2:0] cfg_addr,
    output logic cfg_wr,
    output logic cfg_rd,
    output logic [31:0] cfg_wdata,
    input wire logic [31:0] cfg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        cfg_addr = 3'h0;
        cfg_wr = 1'b0;
        cfg_rd = 1'b0;
        cfg_wdata = 32'h0;
    end
    task automatic cfg_write(input logic [2:0] a, input logic [31:0] d);
        @(negedge mclk);
        cfg_addr = a;
        cfg_wdata = d;
        cfg_wr = 1'b1;
        @(negedge mclk);
        cfg_wr = 1'b0;
        // Stale data never looks valid
        cfg_wdata = ~d;
    endtask
    task automatic cfg_read(input logic [2:0] a, output logic [31:0] d);
        @(negedge mclk);
        cfg_addr = a;
        cfg_rd = 1'b1;
        @(negedge mclk);
        cfg_rd = 1'b0;
        d = cfg_rdata;
    endtask
endmodule
`default_nettype wire

// *** sim/dscr_regs_bench.sv ***
`default_nettype none
module dscr_regs_bench
    import dscr_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic mclk = 1'b0, sys_rst = 1'b1, osc_rst = 1'b1, osc_enable = 1'b0, osc_tick = 1'b0;
    logic dbg_mode = 1'b0, ps_wr = 1'b0, ps_rd = 1'b0, dbg_enter = 1'b0, ps_rvalid;
    logic [7:0] ps_addr = 8'h0, ent_thread = 8'h0, core_stop;
    logic [31:0] ps_wdata = 32'h0, ent_pc = 32'h0, ent_sp = 32'h0, ps_rdata, cfg_rdata;
    logic [31:0] ent_addr = 32'h0, ent_res_id = 32'h0, cfg_wdata;
    logic [10:0] ent_status = 11'h0;
    logic [2:0] ent_cause = 3'h0, cfg_addr;
    logic [3:0] ent_hits = 4'h0;
    logic cfg_wr, cfg_rd;
    int errors = 0;
    int checks = 0;
    always #2 mclk = ~mclk;
    dscr_regs i_dscr_regs (.mclk(mclk), .sys_rst(sys_rst), .osc_rst(osc_rst),
        .osc_enable(osc_enable), .osc_tick(osc_tick), .dbg_mode(dbg_mode), .ps_addr(ps_addr),
        .ps_wr(ps_wr), .ps_rd(ps_rd), .ps_wdata(ps_wdata), .ps_rdata(ps_rdata),
        .ps_rvalid(ps_rvalid), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr), .cfg_rd(cfg_rd),
        .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata), .dbg_enter(dbg_enter),
        .ent_status(ent_status), .ent_pc(ent_pc), .ent_sp(ent_sp), .ent_cause(ent_cause),
        .ent_thread(ent_thread), .ent_hits(ent_hits), .ent_addr(ent_addr),
        .ent_res_id(ent_res_id), .core_stop(core_stop));
    dscr_jtag_model i_dscr_jtag_model (.mclk(mclk), .cfg_addr(cfg_addr), .cfg_wr(cfg_wr),
        .cfg_rd(cfg_rd), .cfg_wdata(cfg_wdata), .cfg_rdata(cfg_rdata));
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            errors++;
            $display("CHECK FAILED at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic rdc(input logic [7:0] a, input logic [31:0] exp);
        @(negedge mclk);
        ps_addr = a;
        ps_rd = 1'b1;
        @(negedge mclk);
        ps_rd = 1'b0;
        chk({31'h0, ps_rvalid}, 32'h1);
        chk(ps_rdata, exp);
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(negedge mclk);
        ps_addr = a;
        ps_wdata = d;
        ps_wr = 1'b1;
        @(negedge mclk);
        ps_wr = 1'b0;
    endtask
    task automatic t_basic();
        rdc(OFF_MEM_CAP, {RAM_BYTES_DEF[31:2], 2'b00});
        rdc(8'h0b, 32'h0);
        rdc(OFF_CAUSE, 32'h0);
        $display("test basic done");
    endtask
    task automatic t_capture();
        logic [31:0] pay;
        logic [31:0] exp_cause;
        pay = 32'h0;
        for (int c = 1; c <= 5; c++) begin
            @(negedge mclk);
            dbg_enter = 1'b1;
            ent_cause = c[2:0];
            ent_hits = 4'h6;
            ent_status = c[0] ? 11'h7ff : 11'h02a;
            ent_thread = 8'h5a;
            ent_pc = 32'h1000_0000 + c;
            ent_sp = 32'h2000_0000 + c;
            ent_addr = 32'hadd0_0000 + c;
            ent_res_id = 32'h7e50_0000 + c;
            @(negedge mclk);
            dbg_enter = 1'b0;
            if (c == 4) pay = 32'hadd0_0004;
            if (c == 5) pay = 32'h7e50_0005;
            rdc(OFF_STAT, c[0] ? 32'h0000_07df : 32'h0000_000a);
            rdc(OFF_PC, 32'h1000_0000 + c);
            rdc(OFF_SP, 32'h2000_0000 + c);
            exp_cause = {14'h0, (c > 2) ? 2'h1 : 2'h0, (c == 1) ? 8'h0 : 8'h5a, 5'h0, c[2:0]};
            rdc(OFF_CAUSE, exp_cause);
            rdc(OFF_PAYLOAD, pay);
        end
        $display("test capture done");
    endtask
    task automatic t_write();
        wr(OFF_T_SEL, 32'hffff_ffff);
        rdc(OFF_T_SEL, 32'h0);
        dbg_mode = 1'b1;
        wr(OFF_T_SEL, 32'hffff_ffff);
        rdc(OFF_T_SEL, 32'h0000_00ff);
        wr(OFF_R_SEL, 32'hffff_ffff);
        rdc(OFF_R_SEL, 32'h0000_001f);
        wr(OFF_PC, 32'h1234_5678);
        rdc(OFF_PC, 32'h1234_5678);
        wr(OFF_PAYLOAD, 32'h5a5a_a5a5);
        rdc(OFF_PAYLOAD, 32'h5a5a_a5a5);
        wr(OFF_STAT, 32'hffff_ffff);
        rdc(OFF_STAT, 32'h0000_07df);
        wr(OFF_STAT, 32'h0);
        rdc(OFF_STAT, 32'h0000_0100);
        wr(OFF_CAUSE, 32'hffff_ffff);
        rdc(OFF_CAUSE, 32'h0003_ff07);
        $display("test write done");
    endtask
    task automatic t_hold();
        wr(OFF_HOLD, 32'hffff_ff05);
        rdc(OFF_HOLD, 32'h0000_0005);
        chk({24'h0, core_stop}, 32'h0);
        dbg_mode = 1'b0;
        repeat (2) @(negedge mclk);
        chk({24'h0, core_stop}, 32'h5);
        $display("test hold done");
    endtask
    task automatic t_mbox();
        logic [31:0] w;
        i_dscr_jtag_model.cfg_write(3'h3, 32'hcafe_0003);
        rdc(8'h23, 32'hcafe_0003);
        wr(8'h23, 32'h1111_1111);
        rdc(8'h23, 32'hcafe_0003);
        dbg_mode = 1'b1;
        wr(8'h27, 32'hbeef_0007);
        // Same word from both sides in one cycle: processor side wins
        fork
            wr(8'h25, 32'h5555_0005);
            i_dscr_jtag_model.cfg_write(3'h5, 32'h0bad_0005);
        join
        rdc(8'h25, 32'h5555_0005);
        // Config read right behind a processor write sees the new word
        fork
            wr(8'h26, 32'h6666_0006);
            begin
                @(negedge mclk);
                i_dscr_jtag_model.cfg_read(3'h6, w);
            end
        join
        chk(w, 32'h6666_0006);
        dbg_mode = 1'b0;
        i_dscr_jtag_model.cfg_read(3'h7, w);
        chk(w, 32'hbeef_0007);
        $display("test mailbox done");
    endtask
    task automatic t_osc();
        @(negedge mclk);
        osc_rst = 1'b1;
        @(negedge mclk);
        osc_rst = 1'b0;
        osc_enable = 1'b1;
        repeat (5) begin
            @(negedge mclk);
            osc_tick = 1'b1;
            @(negedge mclk);
            osc_tick = 1'b0;
        end
        osc_enable = 1'b0;
        repeat (10) @(negedge mclk);
        rdc(OFF_OSC_PWIRE, 32'h5);
        sys_rst = 1'b1;
        repeat (2) @(negedge mclk);
        sys_rst = 1'b0;
        rdc(OFF_OSC_PWIRE, 32'h5);
        rdc(OFF_CAUSE, 32'h0);
        chk({24'h0, core_stop}, 32'h0);
        $display("test oscillator done");
    endtask
    task automatic end_of_test();
        $display("checks %0d errors %0d", checks, errors);
        if (errors == 0 && checks > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask
    // Tests need under two hundred cycles; allow far more
    initial begin
        #20000;
        errors++;
        end_of_test();
    end
    initial begin
        // Counter has no system reset; clear it once while the rest is held
        repeat (2) @(negedge mclk);
        osc_rst = 1'b0;
        repeat (18) @(negedge mclk);
        sys_rst = 1'b0;
        t_basic();
        t_capture();
        t_write();
        t_hold();
        t_mbox();
        t_osc();
        end_of_test();
    end
endmodule
`default_nettype wire
